// ===== design/mil_core.sv
// module: interrupt combining and over-temperature pin logic of the hardware monitor
`timescale 1ns/10ps
// What this block does
// RL1: fan status set only on counter above limit
// RL2: unmasked fan bits ORed set fan latch
// RL3: cleared fan latch waits two fan cycle ends
// RL4: asserted gpio sixteen input sets status bit 7
// RL5: intrusion sets status bit 6
// RL6: gpio and intrusion feed interrupt unlatched
// RL7: interrupt needs enable bit high, clear low
// RL8: first status read clears interrupt and statuses
// RL9: alert response address clears the interrupt
// RL10: clear bit clears the interrupt output
// RL11: over critical drives pin low, fans full
// RL12: over-temperature output needs enable bit 4
// RL13: first over critical, no sensor already hot, sets status bit 3, pin enabled or not
// RL14: only three critical limits drive the pin
// RL15: release only when all sensors 5 below
// RL16: each pin output change raises interrupt once
// RL17: external low on pin forces fans full
// RL18: gpio mode ignores low pin for fans
// RL19: interrupt output is active low
// RL20: pin input synchronised before use
module mil_core
   import mil_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire mil_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic ara_received,
   input wire mil_fan_meas_t fan_meas,
   input wire logic fan_cycle_end,
   input wire logic [7:0] fan_mask,
   input wire mil_temp_meas_t temp_meas,
   input wire logic [7:0] status4_mask,
   input wire logic intrusion_input,
   input wire logic overtemp_pin_n_in,
   output logic overtemp_pin_n_out,
   output logic overtemp_pin_n_oe_n,
   output logic int_pin_n_out,
   output logic int_pin_n_oe_n,
   input wire logic [7:0] pwm_duty_in,
   input wire logic [7:0] dac_level_in,
   output logic [7:0] pwm_duty_out,
   output logic [7:0] dac_level_out,
   output logic fans_forced,
   output logic [7:0] fan_status
);

   ////////////////////////////////////////////////////////////////////////////////
   // state and decode helpers

   mil_state_t st_reg; // all registered state
   mil_state_t st_next; // next value of all state

   // one decoder shared by writes and the first status read
   function automatic logic hit(input mil_reg_req_t r, input logic [7:0] a);
      hit = (r.addr == a);
   endfunction

   logic clear_evt; // any of the three ways to clear the interrupt
   logic first_rd; // read of the first status register
   logic gpio_mode; // shared pin works as general-purpose pin
   logic gpio_asserted; // general-purpose pin sixteen status bit
   logic src_any; // OR of every interrupt source
   logic int_active; // interrupt pin pulled low
   logic ext_low; // outside party pulls the pin low
   logic ot_now; // next pin drive state from the thermal side
   logic [8:0] t_ext; // widened temperature for the release compare
   logic [8:0] l_ext; // widened limit for the release compare
   logic [7:0] st4_view; // fourth status register as read

   ////////////////////////////////////////////////////////////////////////////////
   // combinational views of the state

   always_comb begin
      first_rd = reg_req.rd && hit(reg_req, MIL_ADDR_FIRST_STATUS);
      // level of the clear bit keeps the fan latch clear while it stays set; a pin drive edge still sets the edge latch
      clear_evt = first_rd || ara_received || st_reg.cfg1[MIL_P_INT_CLR]; // RL8 RL9 RL10
      gpio_mode = st_reg.cfg3[MIL_S_GPIO_MODE];
      // input mode follows the pin, output mode shows the written bit
      if (st_reg.cfg3[MIL_S_GPIO_DIR]) begin
         gpio_asserted = st_reg.gpio_out;
      end else if (gpio_mode) begin
         gpio_asserted = st_reg.cfg3[MIL_S_GPIO_POL] ? st_reg.pin_s2 : !st_reg.pin_s2; // RL4
      end else begin
         gpio_asserted = 1'b0;
      end
      // gpio and intrusion go straight in, no latch to clear
      src_any = st_reg.fan_latch || st_reg.ot_latch
         || (gpio_asserted && !status4_mask[MIL_ST_GPIO])
         || (st_reg.ci_s2 && !status4_mask[MIL_ST_CI]); // RL2 RL6
      int_active = st_reg.cfg1[MIL_P_INT_EN] && !st_reg.cfg1[MIL_P_INT_CLR] && src_any; // RL7
      // only the second stage of the synchroniser is looked at
      ext_low = !st_reg.pin_s2 && !gpio_mode; // RL17 RL18 RL20
      st4_view = '0;
      st4_view[MIL_ST_GPIO] = gpio_asserted; // RL4
      st4_view[MIL_ST_CI] = st_reg.ci_s2; // RL5
      st4_view[MIL_ST_OT] = st_reg.ot_stat;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      st_next = st_reg;
      t_ext = {1'b0, temp_meas.value};
      l_ext = '0;
      ot_now = 1'b0;
      // synchronisers for the two pins from outside
      st_next.pin_s1 = overtemp_pin_n_in; // RL20
      st_next.pin_s2 = st_reg.pin_s1; // RL20
      st_next.ci_s1 = intrusion_input;
      st_next.ci_s2 = st_reg.ci_s1;

      // register writes
      if (reg_req.wr) begin
         if (hit(reg_req, MIL_ADDR_PRIMARY_CFG)) begin
            st_next.cfg1 = reg_req.wdata;
         end
         if (hit(reg_req, MIL_ADDR_SECONDARY_CFG)) begin
            st_next.cfg3 = reg_req.wdata;
         end
         if (hit(reg_req, MIL_ADDR_CRIT_FIRST)) begin
            st_next.crit[0] = reg_req.wdata;
         end
         if (hit(reg_req, MIL_ADDR_CRIT_SECOND)) begin
            st_next.crit[1] = reg_req.wdata;
         end
         if (hit(reg_req, MIL_ADDR_CRIT_THIRD)) begin
            st_next.crit[2] = reg_req.wdata;
         end
         // pin sixteen data bit is writable only as an output
         if (hit(reg_req, MIL_ADDR_FOURTH_STATUS) && st_reg.cfg3[MIL_S_GPIO_DIR]) begin
            st_next.gpio_out = reg_req.wdata[MIL_ST_GPIO];
         end
      end

      // read data, unmapped offsets read zero
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            MIL_ADDR_PRIMARY_CFG: st_next.rdata = st_reg.cfg1;
            MIL_ADDR_SECONDARY_CFG: st_next.rdata = st_reg.cfg3;
            MIL_ADDR_CRIT_FIRST: st_next.rdata = st_reg.crit[0];
            MIL_ADDR_CRIT_SECOND: st_next.rdata = st_reg.crit[1];
            MIL_ADDR_CRIT_THIRD: st_next.rdata = st_reg.crit[2];
            MIL_ADDR_FOURTH_STATUS: st_next.rdata = st4_view;
            default: st_next.rdata = 8'h00;
         endcase
      end

      // first status read wipes the other status bits; a new event below still wins
      if (first_rd) begin
         st_next.fan_stat = '0; // RL8
         st_next.ot_stat = 1'b0; // RL8
      end

      // fan result: underspeed only, otherwise cleared
      if (fan_meas.valid) begin
         st_next.fan_stat[fan_meas.sel] = (fan_meas.count > fan_meas.limit); // RL1
      end

      // fan hold-off counts fan cycle ends after a clear
      if (fan_cycle_end && st_reg.fan_wait != 2'h0) begin
         st_next.fan_wait = st_reg.fan_wait - 2'h1;
      end
      if (clear_evt) begin
         st_next.fan_latch = 1'b0; // RL3
         st_next.fan_wait = MIL_FAN_HOLDOFF; // RL3
      end else if (st_reg.fan_wait == 2'h0 && |(st_reg.fan_stat & ~fan_mask)) begin
         st_next.fan_latch = 1'b1; // RL2
      end

      // temperature result against its own critical limit only
      if (temp_meas.valid && temp_meas.sel != 2'h3) begin
         l_ext = {1'b0, st_reg.crit[temp_meas.sel]}; // RL14
         if (temp_meas.value > st_reg.crit[temp_meas.sel]) begin
            st_next.hot[temp_meas.sel] = 1'b1; // RL11
         end else if (t_ext + MIL_HYST_DEG <= l_ext) begin
            // release needs the full margin; in between the sensor stays hot
            st_next.hot[temp_meas.sel] = 1'b0; // RL15
         end
      end
      // the first exceeded limit, with no sensor already hot, sets the status even with the pin disabled
      if (|st_next.hot && !(|st_reg.hot)) begin
         st_next.ot_stat = 1'b1; // RL13
      end

      // pin drive follows the any-hot flag when the function is enabled
      ot_now = (|st_next.hot) && st_next.cfg1[MIL_P_OT_EN] && !st_next.cfg3[MIL_S_GPIO_MODE]; // RL12
      st_next.ot_drv = ot_now; // RL11
      // edge of the pin drive raises the interrupt once; set wins over clear
      if (ot_now != st_reg.ot_drv && !status4_mask[MIL_ST_OT]) begin
         st_next.ot_latch = 1'b1; // RL16
      end else if (clear_evt) begin
         st_next.ot_latch = 1'b0; // RL16
      end

      // fail-safe cooling: own drive or outside low
      st_next.full = st_reg.ot_drv || ext_low; // RL11 RL17
      st_next.pwm = st_next.full ? MIL_FULL_SCALE : pwm_duty_in; // RL11
      st_next.dac = st_next.full ? MIL_FULL_SCALE : dac_level_in; // RL11
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_reg <= MIL_STATE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign reg_rdata = st_reg.rdata;
   assign fan_status = st_reg.fan_stat;
   assign fans_forced = st_reg.full;
   assign pwm_duty_out = st_reg.pwm;
   assign dac_level_out = st_reg.dac;
   // open-drain pins only ever pull low
   assign int_pin_n_out = 1'b0;
   assign int_pin_n_oe_n = !int_active; // RL19
   assign overtemp_pin_n_out = 1'b0;
   // in gpio output mode a low level is the only one driven
   assign overtemp_pin_n_oe_n = gpio_mode
      ? !(st_reg.cfg3[MIL_S_GPIO_DIR]
          && (st_reg.cfg3[MIL_S_GPIO_POL] ? !st_reg.gpio_out : st_reg.gpio_out))
      : !st_reg.ot_drv; // RL11 RL18

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   property p_fan_cmp;
      fan_meas.valid |=> st_reg.fan_stat[$past(fan_meas.sel)]
         == ($past(fan_meas.count) > $past(fan_meas.limit));
   endproperty
   a_fan_cmp: assert property (p_fan_cmp) // RL1
      else $error("fan status does not match the underspeed compare");

   property p_fan_holdoff;
      (st_reg.fan_wait != 2'h0) |-> !st_reg.fan_latch;
   endproperty
   a_fan_holdoff: assert property (p_fan_holdoff) // RL3
      else $error("fan latch set during hold-off");

   property p_fan_set;
      (st_reg.fan_wait == 2'h0 && |(st_reg.fan_stat & ~fan_mask) && !clear_evt)
         |=> st_reg.fan_latch;
   endproperty
   a_fan_set: assert property (p_fan_set) // RL2
      else $error("unmasked fan status failed to set the latch");

   property p_int_gate;
      !int_pin_n_oe_n |-> st_reg.cfg1[MIL_P_INT_EN] && !st_reg.cfg1[MIL_P_INT_CLR];
   endproperty
   a_int_gate: assert property (p_int_gate) // RL7
      else $error("interrupt low while disabled or cleared");

   property p_ci_int;
      (st_reg.ci_s2 && !status4_mask[MIL_ST_CI] && st_reg.cfg1[MIL_P_INT_EN]
         && !st_reg.cfg1[MIL_P_INT_CLR]) |-> !int_pin_n_oe_n;
   endproperty
   a_ci_int: assert property (p_ci_int) // RL6
      else $error("unmasked intrusion did not pull the interrupt low");

   property p_ara_clear;
      (ara_received && $stable(st_reg.ot_drv)) |=> !st_reg.fan_latch ##1 !st_reg.fan_latch;
   endproperty
   a_ara_clear: assert property (p_ara_clear) // RL9
      else $error("fan latch not cleared by alert response");

   property p_full_out;
      st_reg.full |-> (pwm_duty_out == MIL_FULL_SCALE) && (dac_level_out == MIL_FULL_SCALE);
   endproperty
   a_full_out: assert property (p_full_out) // RL11
      else $error("fan outputs not full scale while forced");

   property p_drv_full;
      st_reg.ot_drv |=> st_reg.full;
   endproperty
   a_drv_full: assert property (p_drv_full) // RL11
      else $error("driven pin did not force the fans");

   property p_ot_stat;
      ((|st_reg.hot) && !$past(|st_reg.hot)) |-> st_reg.ot_stat;
   endproperty
   a_ot_stat: assert property (p_ot_stat) // RL13
      else $error("exceeded limit did not set status bit 3");

   property p_release;
      $fell(|st_reg.hot) |-> $past(temp_meas.valid);
   endproperty
   a_release: assert property (p_release) // RL15
      else $error("pin released without a measurement");

   // outputs are checked on the same edge as the forced flag: the pin may already be back high
   property p_ext_full;
      (!st_reg.pin_s2 && !gpio_mode) |=> st_reg.full && (pwm_duty_out == MIL_FULL_SCALE);
   endproperty
   a_ext_full: assert property (p_ext_full) // RL17
      else $error("outside low on the pin did not force the fans");

   property p_sync;
      st_reg.pin_s2 == $past(st_reg.pin_s1, 1);
   endproperty
   a_sync: assert property (p_sync) // RL20
      else $error("pin synchroniser stage skipped");

   ////////////////////////////////////////////////////////////////////////////////
   // clearing and edge behaviour of the latches

   // a change of the pin drive always lands in the edge latch unless masked
   property p_ot_edge;
      ($changed(st_reg.ot_drv) && !$past(status4_mask[MIL_ST_OT])) |-> st_reg.ot_latch;
   endproperty
   a_ot_edge: assert property (p_ot_edge) // RL16
      else $error("pin drive change did not raise the interrupt");

   // a clear leaves the edge latch low unless the drive changed again
   property p_ot_clear;
      clear_evt |=> $changed(st_reg.ot_drv) || !st_reg.ot_latch;
   endproperty
   a_ot_clear: assert property (p_ot_clear) // RL16
      else $error("edge latch survived a clear while the pin stayed");

   // first status read wipes the fan bits and the fan latch
   property p_first_rd;
      (first_rd && !fan_meas.valid) |=> (st_reg.fan_stat == 8'h00) && !st_reg.fan_latch;
   endproperty
   a_first_rd: assert property (p_first_rd) // RL8
      else $error("first status read did not clear fan status");

   // the clear bit drops the fan latch at the next edge
   property p_clr_bit;
      st_reg.cfg1[MIL_P_INT_CLR] |=> !st_reg.fan_latch;
   endproperty
   a_clr_bit: assert property (p_clr_bit) // RL10
      else $error("clear bit left the fan latch set");

   // in general-purpose mode a low pin never forces the fans
   property p_gpio_nofull;
      (gpio_mode && $past(gpio_mode)) |-> !st_reg.full && !st_reg.ot_drv;
   endproperty
   a_gpio_nofull: assert property (p_gpio_nofull) // RL18
      else $error("fans forced while the pin is general purpose");

endmodule // mil_core

// ===== design/mil_pkg.sv
// package: register map, field positions, reset values and carriers for the monitor interrupt logic
package mil_pkg;

   // register offsets (byte addresses on the management bus)
   localparam logic [7:0] MIL_ADDR_PRIMARY_CFG = 8'h00;
   localparam logic [7:0] MIL_ADDR_SECONDARY_CFG = 8'h07;
   localparam logic [7:0] MIL_ADDR_CRIT_FIRST = 8'h0D;
   localparam logic [7:0] MIL_ADDR_CRIT_SECOND = 8'h0E;
   localparam logic [7:0] MIL_ADDR_CRIT_THIRD = 8'h0F;
   localparam logic [7:0] MIL_ADDR_FIRST_STATUS = 8'h20;
   localparam logic [7:0] MIL_ADDR_FOURTH_STATUS = 8'h23;

   // primary configuration fields
   localparam int MIL_P_INT_EN = 1;
   localparam int MIL_P_INT_CLR = 2;
   localparam int MIL_P_OT_EN = 4;
   // secondary configuration fields
   localparam int MIL_S_GPIO_MODE = 0;
   localparam int MIL_S_GPIO_DIR = 6;
   localparam int MIL_S_GPIO_POL = 7;
   // fourth status fields
   localparam int MIL_ST_OT = 3;
   localparam int MIL_ST_CI = 6;
   localparam int MIL_ST_GPIO = 7;

   // fixed hysteresis, degrees per lsb of one
   localparam logic [8:0] MIL_HYST_DEG = 9'h005;
   // fan cycle ends to wait after a clear before the fan latch may set again
   localparam logic [1:0] MIL_FAN_HOLDOFF = 2'h2;
   // reset values and full-scale fan level
   localparam logic [7:0] MIL_CFG_RST = 8'h00;
   localparam logic [7:0] MIL_CRIT_RST = 8'h64;
   localparam logic [7:0] MIL_FULL_SCALE = 8'hFF;

   // register access request from the serial bus front end
   typedef struct packed {
      logic rd; // one-cycle read strobe
      logic wr; // one-cycle write strobe
      logic [7:0] addr; // register offset
      logic [7:0] wdata; // write data
   } mil_reg_req_t;

   // one fan speed result
   typedef struct packed {
      logic valid; // one-cycle strobe
      logic [2:0] sel; // fan number
      logic [7:0] count; // stored counter value
      logic [7:0] limit; // programmed speed limit
   } mil_fan_meas_t;

   // one temperature result
   typedef struct packed {
      logic valid; // one-cycle strobe
      logic [1:0] sel; // sensor 0..2
      logic [7:0] value; // degrees
   } mil_temp_meas_t;

   // whole state of the block
   typedef struct packed {
      logic [7:0] cfg1;
      logic [7:0] cfg3;
      logic [2:0][7:0] crit;
      logic [2:0] hot;
      logic [7:0] fan_stat;
      logic fan_latch;
      logic [1:0] fan_wait;
      logic ot_latch;
      logic ot_stat;
      logic ot_drv;
      logic pin_s1;
      logic pin_s2;
      logic ci_s1;
      logic ci_s2;
      logic gpio_out;
      logic full;
      logic [7:0] pwm;
      logic [7:0] dac;
      logic [7:0] rdata;
   } mil_state_t;

   localparam mil_state_t MIL_STATE_RST = '{
      cfg1: MIL_CFG_RST, cfg3: MIL_CFG_RST,
      crit: {3{MIL_CRIT_RST}}, pin_s1: 1'b1, pin_s2: 1'b1,
      default: '0};

endpackage

// ===== tb/mil_host.sv
// host model: register master and alert response sender on the management bus
`timescale 1ns/10ps
module mil_host
   import mil_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata,
   output mil_reg_req_t reg_req,
   output logic ara_received
);
   // idle bus from time zero
   initial begin
      reg_req = '0;
      ara_received = 1'b0;
   end
   // single byte write; an idle edge follows so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
      @(posedge ref_clk);
      reg_req <= '0;
      @(posedge ref_clk);
   endtask
   // single byte read; data taken once the registered answer has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      reg_req <= '0;
      @(negedge ref_clk);
      v = reg_rdata;
      @(posedge ref_clk);
   endtask
   // alert response address seen on the wire: one-cycle notice
   task automatic ara();
      ara_received <= 1'b1;
      @(posedge ref_clk);
      ara_received <= 1'b0;
      @(posedge ref_clk);
   endtask
endmodule // mil_host

// ===== tb/testbench.sv
// testbench: self-checking bench for the monitor interrupt and over-temperature logic
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; \
   $display("ERROR %s expected %h seen %h", n, e, a); end end
module testbench;
   import mil_pkg::*;
   ////////////////////////////////////////
   // stimulus, observed outputs, model state
   logic ref_clk = 1'b0;
   logic srst = 1'b1; // held 6 cycles at start
   mil_reg_req_t reg_req;
   logic ara_received;
   mil_fan_meas_t fan_meas = '0;
   mil_temp_meas_t temp_meas = '0;
   logic fan_cycle_end = 1'b0;
   logic [7:0] fan_mask = 8'h00;
   logic [7:0] status4_mask = 8'h00;
   logic intrusion_input = 1'b0;
   logic ext_low = 1'b0; // outside party pulling the shared pin
   logic [7:0] pwm_in = 8'h00;
   logic [7:0] dac_in = 8'h00;
   logic [7:0] reg_rdata, pwm_out, dac_out, fan_status;
   logic ot_oe_n, int_oe_n, fans_forced, ot_out, int_out;
   // pull-up on the pin; low when either party pulls it
   wire ot_pin = ((ot_oe_n === 1'b0 && ot_out === 1'b0) || ext_low) ? 1'b0 : 1'b1;
   int errors = 0;
   int samples_checked = 0;
   int crit[3]; // model limits
   int s;
   logic [2:0] hot = 3'h0; // per-sensor over-limit, with hysteresis
   logic oe = 1'b0; // over-temperature output enabled
   logic gm = 1'b0; // shared pin in general-purpose mode
   logic [7:0] fs = 8'h00; // fan underspeed bits
   logic [7:0] d;
   logic [31:0] seed = 32'h0000002F; // xorshift start
   mil_core mil_core_inst (.ref_clk(ref_clk), .srst(srst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .ara_received(ara_received), .fan_meas(fan_meas),
      .fan_cycle_end(fan_cycle_end), .fan_mask(fan_mask), .temp_meas(temp_meas),
      .status4_mask(status4_mask), .intrusion_input(intrusion_input),
      .overtemp_pin_n_in(ot_pin), .overtemp_pin_n_out(ot_out), .overtemp_pin_n_oe_n(ot_oe_n),
      .int_pin_n_out(int_out), .int_pin_n_oe_n(int_oe_n), .pwm_duty_in(pwm_in),
      .dac_level_in(dac_in), .pwm_duty_out(pwm_out), .dac_level_out(dac_out),
      .fans_forced(fans_forced), .fan_status(fan_status));
   mil_host mil_host_inst (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_req(reg_req),
      .ara_received(ara_received));
   ////////////////////////////////////////
   // helpers
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // one temperature result; model applies the 5 degree band
   task automatic temp(input int k, input int v);
      temp_meas <= '{valid: 1'b1, sel: 2'(k), value: 8'(v)};
      @(posedge ref_clk);
      temp_meas.valid <= 1'b0;
      if (v > crit[k]) hot[k] = 1'b1;
      else if (v + 5 <= crit[k]) hot[k] = 1'b0;
      step(6);
   endtask
   // one fan result; underspeed only when counter exceeds limit
   task automatic fan(input int k, input logic [7:0] c, input logic [7:0] l);
      fan_meas <= '{valid: 1'b1, sel: 3'(k), count: c, limit: l};
      @(posedge ref_clk);
      fan_meas.valid <= 1'b0;
      fs[k] = c > l;
      step(4);
   endtask
   // end of one fan monitoring cycle
   task automatic cyc();
      fan_cycle_end <= 1'b1;
      @(posedge ref_clk);
      fan_cycle_end <= 1'b0;
      step(3);
   endtask
   // first status read: clears latches and fan bits
   task automatic clr();
      mil_host_inst.rd(MIL_ADDR_FIRST_STATUS, d);
      fs = 8'h00;
      step(2);
   endtask
   // read and compare the bits selected by m
   task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      mil_host_inst.rd(a, d);
      `CHK("reg_rdata", e, d & m)
   endtask
   // primary configuration write, over-temperature enable tracked in the model
   task automatic cfg(input logic [7:0] v);
      mil_host_inst.wr(MIL_ADDR_PRIMARY_CFG, v);
      oe = v[MIL_P_OT_EN];
      step(1);
   endtask
   // every observed output but reg_rdata against the model, away from the edge
   task automatic chk(input logic on);
      logic pin;
      logic frc;
      pin = oe && (|hot);
      frc = pin || (ext_low && !gm);
      @(negedge ref_clk);
      `CHK("int_oe_n", ~on, int_oe_n)
      `CHK("int_out", 1'b0, int_out)
      `CHK("pin_out", 1'b0, ot_out)
      `CHK("pin_oe_n", ~pin, ot_oe_n)
      `CHK("forced", frc, fans_forced)
      `CHK("pwm", frc ? 8'hFF : pwm_in, pwm_out)
      `CHK("dac", frc ? 8'hFF : dac_in, dac_out)
      `CHK("fan_status", fs, fan_status)
      @(posedge ref_clk);
   endtask
   task automatic test_done();
      if (errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // main sequence
   initial begin
      step(6);
      srst <= 1'b0;
      @(posedge ref_clk);
      rdc(MIL_ADDR_PRIMARY_CFG, 8'hFF, MIL_CFG_RST);
      rdc(MIL_ADDR_SECONDARY_CFG, 8'hFF, MIL_CFG_RST);
      rdc(8'h3F, 8'hFF, 8'h00);
      // limits: reset value, random write, read back
      for (int i = 0; i < 3; i++) begin
         rdc(MIL_ADDR_CRIT_FIRST + 8'(i), 8'hFF, MIL_CRIT_RST);
         crit[i] = 60 + int'(rnd() % 64);
         mil_host_inst.wr(MIL_ADDR_CRIT_FIRST + 8'(i), 8'(crit[i]));
         rdc(MIL_ADDR_CRIT_FIRST + 8'(i), 8'hFF, 8'(crit[i]));
      end
      // random readings near the limits, interrupt disabled
      cfg(8'h10);
      for (int k = 0; k < 24; k++) begin
         pwm_in <= 8'(rnd());
         dac_in <= 8'(rnd());
         s = int'(rnd() % 3);
         temp(s, crit[s] - 8 + int'(rnd() % 16));
         chk(1'b0);
      end
      for (int i = 0; i < 3; i++) temp(i, 0);
      clr();
      // edge-triggered interrupt from the pin drive
      cfg(8'h12);
      chk(1'b0);
      temp(0, crit[0] + 1);
      chk(1'b1);
      rdc(MIL_ADDR_FOURTH_STATUS, 8'h08, 8'h08);
      clr();
      chk(1'b0);
      temp(0, crit[0] - 4);
      chk(1'b0);
      temp(0, crit[0] - 5);
      chk(1'b1);
      mil_host_inst.ara();
      chk(1'b0);
      temp(1, crit[1] + 1);
      cfg(8'h16);
      chk(1'b0);
      cfg(8'h12);
      chk(1'b0);
      temp(1, 0);
      chk(1'b1);
      clr();
      // function disabled: status records, pin and fans untouched
      cfg(8'h02);
      temp(2, crit[2] + 1);
      chk(1'b0);
      rdc(MIL_ADDR_FOURTH_STATUS, 8'h08, 8'h08);
      temp(2, 0);
      clr();
      // outside pull forces fans until released
      ext_low <= 1'b1;
      step(6);
      chk(1'b0);
      ext_low <= 1'b0;
      step(6);
      chk(1'b0);
      // general-purpose input, active low: no forcing, unlatched status
      mil_host_inst.wr(MIL_ADDR_SECONDARY_CFG, 8'h01);
      gm = 1'b1;
      ext_low <= 1'b1;
      step(6);
      chk(1'b1);
      rdc(MIL_ADDR_FOURTH_STATUS, 8'h80, 8'h80);
      clr();
      chk(1'b1);
      status4_mask <= 8'h80;
      step(2);
      chk(1'b0);
      ext_low <= 1'b0;
      status4_mask <= 8'h00;
      step(4);
      intrusion_input <= 1'b1;
      step(4);
      rdc(MIL_ADDR_FOURTH_STATUS, 8'h40, 8'h40);
      clr();
      chk(1'b1);
      intrusion_input <= 1'b0;
      step(4);
      chk(1'b0);
      // fan latch: mask, boundary, hold-off after a clear
      cyc();
      cyc();
      fan_mask <= 8'h04;
      fan(2, 8'h90, 8'h80);
      chk(1'b0);
      fan(3, 8'h80, 8'h80);
      chk(1'b0);
      fan(3, 8'h81, 8'h80);
      chk(1'b1);
      clr();
      fan(3, 8'h81, 8'h80);
      chk(1'b0);
      cyc();
      chk(1'b0);
      cyc();
      chk(1'b1);
      // pin sixteen as active-high output: written bit drives the pin, never the fans
      status4_mask <= 8'h80;
      mil_host_inst.wr(MIL_ADDR_SECONDARY_CFG, 8'hC1);
      for (int b = 1; b >= 0; b--) begin
         mil_host_inst.wr(MIL_ADDR_FOURTH_STATUS, 8'(b << 7));
         step(3);
         @(negedge ref_clk);
         `CHK("pin_oe_n", b[0], ot_oe_n)
         `CHK("forced", 1'b0, fans_forced)
         @(posedge ref_clk);
         rdc(MIL_ADDR_FOURTH_STATUS, 8'h80, 8'(b << 7));
      end
      // reset in mid-run: registers back to defaults, nothing left pulled
      srst <= 1'b1;
      step(3);
      srst <= 1'b0;
      @(posedge ref_clk);
      fs = 8'h00;
      gm = 1'b0;
      rdc(MIL_ADDR_PRIMARY_CFG, 8'hFF, MIL_CFG_RST);
      rdc(MIL_ADDR_CRIT_SECOND, 8'hFF, MIL_CRIT_RST);
      chk(1'b0);
      test_done();
   end
   // watchdog: tests need about 470 cycles, allow over forty times that
   initial begin
      #400000;
      errors++;
      test_done();
   end
endmodule // testbench
